// ===== hw/asjsc_cfg.svh
// Register offsets, control bits, reset values and fault codes
`ifndef ASJSC_CFG_SVH
`define ASJSC_CFG_SVH
`define ASJSC_A_CTRL   8'h00
`define ASJSC_A_SKIPN  8'h04
`define ASJSC_A_ODIST  8'h08
`define ASJSC_A_OSPD   8'h0c
`define ASJSC_A_OACC   8'h10
`define ASJSC_A_HDEC   8'h14
`define ASJSC_A_OJRK   8'h18
`define ASJSC_A_JHI    8'h1c
`define ASJSC_A_JLO    8'h20
`define ASJSC_A_JACC   8'h24
`define ASJSC_A_JDEC   8'h28
`define ASJSC_A_JJRK   8'h2c
`define ASJSC_A_STAT   8'h30
`define ASJSC_A_FAULT  8'h34
`define ASJSC_A_BYP    8'h38
`define ASJSC_A_POS    8'h3c
`define ASJSC_A_TRAV   8'h40
`define ASJSC_A_FSKIP  8'h44
`define ASJSC_C_SKIP   0
`define ASJSC_C_OVL    1
`define ASJSC_C_HALT   2
`define ASJSC_C_JOGEN  3
`define ASJSC_C_JDIR   4
`define ASJSC_C_JHIGH  5
`define ASJSC_NCMD     3
`define ASJSC_CTRL_W   6
`define ASJSC_JHI_RST  32'h000186a0
`define ASJSC_JLO_RST  32'h00002710
`define ASJSC_JACC_RST 32'h000186a0
`define ASJSC_JDEC_RST 32'h000186a0
`define ASJSC_JJRK_RST 32'h00000000
`define ASJSC_OSPD_RST 32'h00002710
`define ASJSC_OACC_RST 32'h000186a0
`define ASJSC_ERR_MODE  16'h1082
`define ASJSC_ERR_NOOVL 16'h1083
`define ASJSC_ERR_NOCAM 16'h1090
`define ASJSC_MODE_VEL 2'h1
`define ASJSC_MODE_TRQ 2'h2
`define ASJSC_HSIZE_W  3'h2
`endif

// ===== hw/asjsc_pkg.sv
// Types shared by the axis command block
package asjsc_pkg;
  typedef enum logic [1:0] {
    SK_IDLE = 2'b00,
    SK_WAIT = 2'b01,
    SK_HOLD = 2'b10
  } asjsc_skip_type;
endpackage

// ===== hw/asjsc_edge.sv
// Rising edge detectors for the edge-type command bits
`timescale 1ns/1ps
`default_nettype none
`include "asjsc_cfg.svh"
module asjsc_edge (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic [`ASJSC_NCMD-1:0]   lvl,
  output logic      [`ASJSC_NCMD-1:0]   rise
);
  logic [`ASJSC_NCMD-1:0] prev_ff;
  genvar i;
  generate
    for (i = 0; i < `ASJSC_NCMD; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rstn) prev_ff[i] <= 1'b0;
        else prev_ff[i] <= lvl[i];
      end
      assign rise[i] = lvl[i] & ~prev_ff[i];
    end
  endgenerate
endmodule
`default_nettype wire

// ===== hw/asjsc_ramp.sv
// Velocity shaper with separate accel, decel and jerk-limited step
`timescale 1ns/1ps
`default_nettype none
module asjsc_ramp (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [31:0] tgt,
  input  wire logic [31:0] acc,
  input  wire logic [31:0] dec,
  input  wire logic [31:0] jerk,
  output logic      [31:0] vel
);
  logic [31:0] vel_ff;
  logic [31:0] stp_ff;
  wire         up  = vel_ff < tgt;
  wire  [31:0] lim = up ? acc : dec;
  wire  [31:0] gap = up ? tgt - vel_ff : vel_ff - tgt;
  wire  [32:0] grow = {1'b0, stp_ff} + {1'b0, jerk};
  // Zero jerk applies the full rate at once
  wire  [31:0] nxt_stp = (jerk == '0 || grow > {1'b0, lim}) ?
                         lim : grow[31:0];
  // Zero rate means an immediate jump to the target
  wire  [31:0] mv = (lim == '0 || nxt_stp >= gap) ? gap : nxt_stp;
  wire  [31:0] nxt_vel = up ? vel_ff + mv : vel_ff - mv;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      vel_ff <= '0;
      stp_ff <= '0;
    end else begin
      vel_ff <= nxt_vel;
      stp_ff <= (gap == '0) ? '0 : nxt_stp;
    end
  end
  assign vel = vel_ff;
endmodule
`default_nettype wire

// ===== hw/asjsc_top.sv
// Cam skip, jog and overlay move command logic with AHB-Lite registers
// Operation
// [RULE1] Skip waits for current cam cycle end
// [RULE2] Skipping holds sub-axis at table end
// [RULE3] Re-execute restarts count, reports request plus one
// [RULE4] Skip active stays until skip completes
// [RULE5] Done and bypassed count shown after completion
// [RULE6] Jog runs regardless of origin, updates position
// [RULE7] Jog uses its own accel, decel, jerk
// [RULE8] Jog speed high or low, given direction
// [RULE9] Software keeps high speed within limits
// [RULE10] Speeds positive only; rates zero or positive
// [RULE11] Overlay moves distance from current position
// [RULE12] Distance sign selects overlay direction
// [RULE13] Overlay adds onto underlying motion
// [RULE14] Overlay continues after underlying motion ends
// [RULE15] At axis_idle_state overlay acts as relative move
// [RULE16] Halt decelerates only the overlay component
// [RULE17] Overlay refused in velocity or torque mode
// [RULE18] Halt refused without running overlay
// [RULE19] Edge commands latch on execute rise; jog level
// [RULE20] Busy, error, fault code, superseded per command; jog reports only busy
`timescale 1ns/1ps
`default_nettype none
`include "asjsc_cfg.svh"
module asjsc_top
  import asjsc_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  input  wire logic        CAM_RUN,
  input  wire logic        CAM_CYCLE_END,
  input  wire logic [1:0]  AXIS_CTRL_MODE,
  input  wire logic [31:0] BASE_VEL,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic      [31:0] AXIS_POS,
  output logic             CAM_HOLD
);
  function automatic logic is_reg(input logic [7:0] a,
                                  input logic [7:0] o);
    is_reg = (a == o);
  endfunction

  logic [7:0]  addr_ff;
  logic        wr_ff;
  logic [`ASJSC_CTRL_W-1:0] ctrl_ff;
  logic [15:0] skipn_ff;
  logic [31:0] dist_ff;
  logic [31:0] ospd_ff;
  logic [31:0] oacc_ff;
  logic [31:0] hdec_ff;
  logic [31:0] ojrk_ff;
  logic [31:0] jhi_ff;
  logic [31:0] jlo_ff;
  logic [31:0] jacc_ff;
  logic [31:0] jdec_ff;
  logic [31:0] jjrk_ff;

  // Bus slave, zero wait states
  wire ahb_go = HSEL & HTRANS[1] & HREADY;
  wire nxt_wr = ahb_go & HWRITE & (HSIZE == `ASJSC_HSIZE_W);
  wire [7:0] nxt_addr = ahb_go ? HADDR[7:0] : addr_ff;
  wire wdat_pos = ~HWDATA[31] & (HWDATA != '0);
  wire wdat_nneg = ~HWDATA[31];
  wire we_ctrl  = wr_ff & is_reg(addr_ff, `ASJSC_A_CTRL);
  wire we_skipn = wr_ff & is_reg(addr_ff, `ASJSC_A_SKIPN);
  wire we_dist  = wr_ff & is_reg(addr_ff, `ASJSC_A_ODIST);
  wire we_ospd  = wr_ff & is_reg(addr_ff, `ASJSC_A_OSPD) & wdat_pos;
  wire we_oacc  = wr_ff & is_reg(addr_ff, `ASJSC_A_OACC) & wdat_nneg;
  wire we_hdec  = wr_ff & is_reg(addr_ff, `ASJSC_A_HDEC) & wdat_nneg;
  wire we_ojrk  = wr_ff & is_reg(addr_ff, `ASJSC_A_OJRK) & wdat_nneg;
  wire we_jhi   = wr_ff & is_reg(addr_ff, `ASJSC_A_JHI) & wdat_pos; // RULE10
  wire we_jlo   = wr_ff & is_reg(addr_ff, `ASJSC_A_JLO) & wdat_pos; // RULE10
  wire we_jacc  = wr_ff & is_reg(addr_ff, `ASJSC_A_JACC) & wdat_nneg; // RULE10
  wire we_jdec  = wr_ff & is_reg(addr_ff, `ASJSC_A_JDEC) & wdat_nneg; // RULE10
  wire we_jjrk  = wr_ff & is_reg(addr_ff, `ASJSC_A_JJRK) & wdat_nneg; // RULE10

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      wr_ff     <= 1'b0;
      addr_ff   <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      wr_ff     <= nxt_wr;
      addr_ff   <= nxt_addr;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ctrl_ff  <= '0;
      skipn_ff <= '0;
      dist_ff  <= '0;
      ospd_ff  <= `ASJSC_OSPD_RST;
      oacc_ff  <= `ASJSC_OACC_RST;
      hdec_ff  <= `ASJSC_OACC_RST;
      ojrk_ff  <= '0;
      jhi_ff   <= `ASJSC_JHI_RST;
      jlo_ff   <= `ASJSC_JLO_RST;
      jacc_ff  <= `ASJSC_JACC_RST;
      jdec_ff  <= `ASJSC_JDEC_RST;
      jjrk_ff  <= `ASJSC_JJRK_RST;
    end else begin
      if (we_ctrl) ctrl_ff <= HWDATA[`ASJSC_CTRL_W-1:0];
      if (we_skipn) skipn_ff <= HWDATA[15:0];
      if (we_dist) dist_ff <= HWDATA;
      if (we_ospd) ospd_ff <= HWDATA;
      if (we_oacc) oacc_ff <= HWDATA;
      if (we_hdec) hdec_ff <= HWDATA;
      if (we_ojrk) ojrk_ff <= HWDATA;
      if (we_jhi) jhi_ff <= HWDATA;
      if (we_jlo) jlo_ff <= HWDATA;
      if (we_jacc) jacc_ff <= HWDATA;
      if (we_jdec) jdec_ff <= HWDATA;
      if (we_jjrk) jjrk_ff <= HWDATA;
    end
  end

  // Edge-type commands fire once per rising execute bit
  logic [`ASJSC_NCMD-1:0] go;
  asjsc_edge u_edge (
    .clk  (CORE_CLK),
    .rstn (RSTN),
    .lvl  (ctrl_ff[`ASJSC_NCMD-1:0]),
    .rise (go)
  ); // RULE19
  wire skip_go = go[`ASJSC_C_SKIP];
  wire ovl_go  = go[`ASJSC_C_OVL];
  wire halt_go = go[`ASJSC_C_HALT];

  // Cam cycle bypass sequencer
  asjsc_skip_type skip_st_ff;
  asjsc_skip_type nxt_skip_st;
  logic [16:0] cnt_ff;
  logic [16:0] lim_ff;
  logic [16:0] nxt_cnt;
  logic [16:0] nxt_lim;
  logic [15:0] byp_ff;
  logic [15:0] skip_fault_ff;
  logic        skip_done_ff;
  logic        skip_abt_ff;
  logic        skip_err_ff;
  wire  [16:0] skipn_ext = {1'b0, skipn_ff};
  wire  skip_fin = (skip_st_ff == SK_HOLD) & (cnt_ff >= lim_ff) & ~skip_go;
  wire  skip_bad = skip_go & (skip_st_ff == SK_IDLE) & ~CAM_RUN;
  wire  skip_busy = (skip_st_ff != SK_IDLE);

  always_comb begin
    nxt_skip_st = skip_st_ff;
    nxt_cnt     = cnt_ff;
    nxt_lim     = lim_ff;
    unique case (skip_st_ff)
      SK_IDLE: begin
        if (skip_go & CAM_RUN) begin
          nxt_skip_st = SK_WAIT; // RULE1
          nxt_cnt     = '0;
          nxt_lim     = skipn_ext;
        end
      end
      SK_WAIT: begin
        if (skip_go) begin
          nxt_lim = skipn_ext; // RULE3
        end else if (CAM_CYCLE_END) begin
          nxt_skip_st = SK_HOLD; // RULE1
        end
      end
      SK_HOLD: begin
        if (skip_go) begin
          // Cycle in progress is counted into the new run
          nxt_cnt = 17'h00001; // RULE3
          nxt_lim = skipn_ext + 17'h00001; // RULE3
        end else if (skip_fin) begin
          nxt_skip_st = SK_IDLE;
        end else if (CAM_CYCLE_END) begin
          nxt_cnt = cnt_ff + 17'h00001; // RULE2
        end
      end
      default: nxt_skip_st = SK_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      skip_st_ff    <= SK_IDLE;
      cnt_ff        <= '0;
      lim_ff        <= '0;
      byp_ff        <= '0;
      skip_done_ff  <= 1'b0;
      skip_abt_ff   <= 1'b0;
      skip_err_ff   <= 1'b0;
      skip_fault_ff <= '0;
      CAM_HOLD      <= 1'b0;
    end else begin
      skip_st_ff <= nxt_skip_st;
      cnt_ff     <= nxt_cnt;
      lim_ff     <= nxt_lim;
      CAM_HOLD   <= (nxt_skip_st == SK_HOLD); // RULE2
      if (skip_fin) begin
        skip_done_ff <= 1'b1; // RULE5
        byp_ff       <= cnt_ff[15:0]; // RULE5
      end else if (skip_go) begin
        skip_done_ff <= 1'b0;
      end
      if (skip_go) begin
        skip_abt_ff   <= skip_busy; // RULE20
        skip_err_ff   <= skip_bad; // RULE20
        skip_fault_ff <= skip_bad ? `ASJSC_ERR_NOCAM : '0;
      end
    end
  end

  // Jog; origin state is deliberately not consulted
  logic        jdir_ff;
  logic [31:0] jvel;
  wire jog_on = ctrl_ff[`ASJSC_C_JOGEN]; // RULE19
  wire [31:0] jtgt = ~jog_on ? '0 :
                     ctrl_ff[`ASJSC_C_JHIGH] ? jhi_ff : jlo_ff; // RULE8
  asjsc_ramp u_jramp (
    .clk  (CORE_CLK),
    .rstn (RSTN),
    .tgt  (jtgt),
    .acc  (jacc_ff),
    .dec  (jdec_ff),
    .jerk (jjrk_ff),
    .vel  (jvel)
  ); // RULE7
  // Direction only changes at rest to avoid reversing at speed
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) jdir_ff <= 1'b0;
    else if (jvel == '0) jdir_ff <= ctrl_ff[`ASJSC_C_JDIR]; // RULE8
  end
  wire [31:0] jstep = jdir_ff ? -jvel : jvel; // RULE8
  wire jog_busy = jog_on | (jvel != '0);

  // Overlay move and its halt
  logic        ovl_busy_ff;
  logic        halt_ff;
  logic        odir_ff;
  logic [31:0] rem_ff;
  logic [31:0] trav_ff;
  logic        ovl_done_ff;
  logic        ovl_abt_ff;
  logic        ovl_err_ff;
  logic [15:0] ovl_fault_ff;
  logic        halt_done_ff;
  logic        halt_abt_ff;
  logic        halt_err_ff;
  logic [15:0] halt_fault_ff;
  logic [31:0] ovel;
  wire mode_bad = (AXIS_CTRL_MODE == `ASJSC_MODE_VEL) |
                  (AXIS_CTRL_MODE == `ASJSC_MODE_TRQ);
  wire [31:0] otgt = (ovl_busy_ff & ~halt_ff) ? ospd_ff : '0;
  wire [31:0] odec = halt_ff ? hdec_ff : oacc_ff; // RULE16
  asjsc_ramp u_oramp (
    .clk  (CORE_CLK),
    .rstn (RSTN),
    .tgt  (otgt),
    .acc  (oacc_ff),
    .dec  (odec),
    .jerk (ojrk_ff),
    .vel  (ovel)
  );
  wire [31:0] ostep = ~ovl_busy_ff ? '0 :
                      (ovel > rem_ff) ? rem_ff : ovel; // RULE14
  wire [31:0] ostep_s = odir_ff ? -ostep : ostep; // RULE12
  wire ovl_fin  = ovl_busy_ff & ~halt_ff & (rem_ff == ostep);
  wire halt_fin = halt_ff & ((ovel == '0) | (rem_ff == ostep));
  wire ovl_ok   = ovl_go & ~mode_bad;
  wire halt_ok  = halt_go & ovl_busy_ff;
  wire [31:0] dist_mag = dist_ff[31] ? -dist_ff : dist_ff;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ovl_busy_ff <= 1'b0;
      halt_ff     <= 1'b0;
      odir_ff     <= 1'b0;
      rem_ff      <= '0;
      trav_ff     <= '0;
    end else if (ovl_ok) begin
      ovl_busy_ff <= 1'b1; // RULE11
      halt_ff     <= 1'b0;
      odir_ff     <= dist_ff[31]; // RULE12
      rem_ff      <= dist_mag; // RULE11
      trav_ff     <= '0;
    end else begin
      rem_ff  <= rem_ff - ostep;
      trav_ff <= trav_ff + ostep_s;
      if (halt_ok) halt_ff <= 1'b1; // RULE16
      if (ovl_fin | halt_fin) begin
        ovl_busy_ff <= 1'b0;
        halt_ff     <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ovl_done_ff   <= 1'b0;
      ovl_abt_ff    <= 1'b0;
      ovl_err_ff    <= 1'b0;
      ovl_fault_ff  <= '0;
      halt_done_ff  <= 1'b0;
      halt_abt_ff   <= 1'b0;
      halt_err_ff   <= 1'b0;
      halt_fault_ff <= '0;
    end else begin
      if (ovl_go) begin
        ovl_done_ff  <= 1'b0;
        ovl_abt_ff   <= ovl_ok & ovl_busy_ff; // RULE20
        ovl_err_ff   <= mode_bad; // RULE17
        ovl_fault_ff <= mode_bad ? `ASJSC_ERR_MODE : '0; // RULE17
      end else begin
        if (ovl_fin) ovl_done_ff <= 1'b1;
        if (halt_fin) ovl_abt_ff <= 1'b1; // RULE20
      end
      if (halt_go) begin
        halt_done_ff  <= 1'b0;
        halt_abt_ff   <= 1'b0;
        halt_err_ff   <= ~ovl_busy_ff; // RULE18
        halt_fault_ff <= ovl_busy_ff ? '0 : `ASJSC_ERR_NOOVL; // RULE18
      end else begin
        if (halt_fin) halt_done_ff <= 1'b1;
        if (ovl_ok & halt_ff) halt_abt_ff <= 1'b1; // RULE20
      end
    end
  end

  // Axis trajectory: underlying motion plus jog plus overlay
  wire [31:0] nxt_pos = AXIS_POS + BASE_VEL + jstep + ostep_s; // RULE13
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) AXIS_POS <= '0;
    else AXIS_POS <= nxt_pos; // RULE6
  end

  // Read-back
  wire [31:0] status = {6'h00, CAM_HOLD, jog_busy, 3'h0,
                        halt_err_ff, halt_abt_ff, halt_ff, halt_ff,
                        halt_done_ff, 3'h0,
                        ovl_err_ff, ovl_abt_ff, ovl_busy_ff, ovl_busy_ff,
                        ovl_done_ff, 3'h0,
                        skip_err_ff, skip_abt_ff, skip_busy, skip_busy,
                        skip_done_ff}; // RULE4
  wire [7:0] ra = HADDR[7:0];
  wire [31:0] rd_mux =
    is_reg(ra, `ASJSC_A_CTRL)  ? {26'h0, ctrl_ff} :
    is_reg(ra, `ASJSC_A_SKIPN) ? {16'h0, skipn_ff} :
    is_reg(ra, `ASJSC_A_ODIST) ? dist_ff :
    is_reg(ra, `ASJSC_A_OSPD)  ? ospd_ff :
    is_reg(ra, `ASJSC_A_OACC)  ? oacc_ff :
    is_reg(ra, `ASJSC_A_HDEC)  ? hdec_ff :
    is_reg(ra, `ASJSC_A_OJRK)  ? ojrk_ff :
    is_reg(ra, `ASJSC_A_JHI)   ? jhi_ff :
    is_reg(ra, `ASJSC_A_JLO)   ? jlo_ff :
    is_reg(ra, `ASJSC_A_JACC)  ? jacc_ff :
    is_reg(ra, `ASJSC_A_JDEC)  ? jdec_ff :
    is_reg(ra, `ASJSC_A_JJRK)  ? jjrk_ff :
    is_reg(ra, `ASJSC_A_STAT)  ? status :
    is_reg(ra, `ASJSC_A_FAULT) ? {halt_fault_ff, ovl_fault_ff} :
    is_reg(ra, `ASJSC_A_BYP)   ? {16'h0, byp_ff} :
    is_reg(ra, `ASJSC_A_POS)   ? AXIS_POS :
    is_reg(ra, `ASJSC_A_TRAV)  ? trav_ff :
    is_reg(ra, `ASJSC_A_FSKIP) ? {16'h0, skip_fault_ff} : '0;
  // Unmapped or upper addresses read as zero
  wire hi_zero = (HADDR[31:8] == '0);
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) HRDATA <= '0;
    else if (ahb_go & ~HWRITE) HRDATA <= hi_zero ? rd_mux : '0;
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  chk_skip_waits: assert property ( // RULE1
    (skip_st_ff == SK_WAIT && !CAM_CYCLE_END) |=> skip_st_ff != SK_HOLD)
    else $error("skip hold entered before cycle end");
  chk_hold_pin: assert property ( // RULE2
    (skip_st_ff == SK_HOLD) |-> CAM_HOLD)
    else $error("sub-axis not held during skip");
  chk_restart_count: assert property ( // RULE3
    (skip_go && skip_st_ff == SK_HOLD) |=>
      (cnt_ff == 17'h00001 && lim_ff == {1'b0, $past(skipn_ff)} + 17'h1))
    else $error("skip restart count wrong");
  chk_active_kept: assert property ( // RULE4
    (skip_busy && !skip_fin) |=> skip_busy)
    else $error("skip active dropped early");
  chk_done_count: assert property ( // RULE5
    $rose(skip_done_ff) |-> (byp_ff == $past(cnt_ff[15:0]) &&
                             skip_st_ff == SK_IDLE))
    else $error("done without final count");
  chk_jog_select: assert property ( // RULE8
    (jog_on && ctrl_ff[`ASJSC_C_JHIGH]) |-> jtgt == jhi_ff)
    else $error("jog speed select wrong");
  chk_mode_reject: assert property ( // RULE17
    (ovl_go && mode_bad) |=> (ovl_err_ff && !$rose(ovl_busy_ff) &&
                              ovl_fault_ff == `ASJSC_ERR_MODE))
    else $error("overlay not refused in velocity or torque");
  chk_halt_reject: assert property ( // RULE18
    (halt_go && !ovl_busy_ff) |=> (halt_err_ff && !halt_ff &&
                                   halt_fault_ff == `ASJSC_ERR_NOOVL))
    else $error("halt not refused without overlay");
  chk_ovl_sign: assert property ( // RULE12
    (ovl_busy_ff && odir_ff) |-> ostep_s[31] || ostep_s == '0)
    else $error("overlay step against distance sign");
endmodule
`default_nettype wire

// ===== sim/asjsc_cam_src.sv
// Cam cycle source and underlying axis motion for the command block
`timescale 1ns/1ps
`default_nettype none
module asjsc_cam_src #(
  parameter int PERIOD = 16
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        cam_en,
  input  wire logic [31:0] base_in,
  output logic             cam_run_ff,
  output logic             cycle_end_ff,
  output logic      [31:0] base_vel
);
  logic [7:0] cnt_ff;
  // Restarting the count on enable keeps the first cycle end far away
  always_ff @(posedge clk) begin
    if (!rstn || !cam_en) begin
      cnt_ff       <= 8'h00;
      cam_run_ff   <= 1'b0;
      cycle_end_ff <= 1'b0;
    end else begin
      cam_run_ff   <= 1'b1;
      cnt_ff       <= (cnt_ff == 8'(PERIOD - 1)) ? 8'h00 : cnt_ff + 8'h01;
      cycle_end_ff <= (cnt_ff == 8'(PERIOD - 1));
    end
  end
  assign base_vel = base_in;
endmodule
`default_nettype wire

// ===== sim/test_axis_skip_jog_superpose_ctrl.sv
// Self-checking bench for the axis command block
`timescale 1ns/1ps
`default_nettype none
`include "asjsc_cfg.svh"
module test_axis_skip_jog_superpose_ctrl;
  logic        clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic        cam_en, cam_run, cyc_end, cam_hold;
  logic [31:0] haddr, hwdata, hrdata, pos, base_in, base_vel, base_sum;
  logic [1:0]  htrans, mode;
  logic [2:0]  hsize;
  logic [5:0]  ctrl;
  int          errors, tests_run, hold_ends;
  asjsc_top asjsc_top_i (.CORE_CLK(clk), .RSTN(rstn), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hready), .CAM_RUN(cam_run),
    .CAM_CYCLE_END(cyc_end), .AXIS_CTRL_MODE(mode), .BASE_VEL(base_vel),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .AXIS_POS(pos), .CAM_HOLD(cam_hold));
  asjsc_cam_src #(.PERIOD(16)) asjsc_cam_src_i (.clk(clk), .rstn(rstn),
    .cam_en(cam_en), .base_in(base_in), .cam_run_ff(cam_run),
    .cycle_end_ff(cyc_end), .base_vel(base_vel));
  assign hready = hreadyout;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Running sum of the underlying motion, to split it from our moves
  always @(posedge clk) begin
    base_sum <= base_sum + base_vel;
    if (cam_hold === 1'b1) hold_ends <= hold_ends + int'(cyc_end);
  end
  task automatic finish_test();
    $display("checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    int n;
    n = 0;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [31:0] a, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(nm, e, q);
  endtask
  task automatic stat(input string nm, input int b, input logic e);
    logic [31:0] q;
    bus(1'b0, `ASJSC_A_STAT, 32'h0, q);
    check(nm, {31'h0, e}, {31'h0, q[b]});
  endtask
  // Exec bits act on a 0 to 1 change; the idle edges let flags clear
  task automatic pulse(input int b);
    ctrl[b] = 1'b0;
    wr(`ASJSC_A_CTRL, {26'h0, ctrl});
    ctrl[b] = 1'b1;
    wr(`ASJSC_A_CTRL, {26'h0, ctrl});
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_stat(input string nm, input int b);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, `ASJSC_A_STAT, 32'h0, q);
      n++;
    end while (q[b] !== 1'b1 && n < 400);
    check(nm, 32'h1, {31'h0, q[b]});
  endtask
  task automatic t_reset();
    check("bus response", 32'h0, {31'h0, hresp});
    rd_chk("jog high", `ASJSC_A_JHI, 32'h000186a0);
    rd_chk("jog low", `ASJSC_A_JLO, 32'h00002710);
    rd_chk("jog accel", `ASJSC_A_JACC, 32'h000186a0);
    rd_chk("jog decel", `ASJSC_A_JDEC, 32'h000186a0);
    rd_chk("jog jerk", `ASJSC_A_JJRK, 32'h0);
    wr(32'h80, 32'h1234);
    rd_chk("unmapped", 32'h80, 32'h0);
    wr(`ASJSC_A_JLO, 32'h0);
    wr(`ASJSC_A_JJRK, 32'hffffffff);
    rd_chk("jog low zero", `ASJSC_A_JLO, 32'h00002710);
    rd_chk("jog jerk neg", `ASJSC_A_JJRK, 32'h0);
  endtask
  // Direction polarity is unknown, so the first run fixes the sign
  task automatic t_jog();
    logic [31:0] p0, e;
    logic        s;
    wr(`ASJSC_A_JLO, 32'h3);
    wr(`ASJSC_A_JHI, 32'h5);
    wr(`ASJSC_A_JACC, 32'h0);
    wr(`ASJSC_A_JDEC, 32'h0);
    for (int i = 0; i < 3; i++) begin
      ctrl[`ASJSC_C_JDIR] = (i == 2);
      ctrl[`ASJSC_C_JHIGH] = (i == 1);
      ctrl[`ASJSC_C_JOGEN] = 1'b1;
      wr(`ASJSC_A_CTRL, {26'h0, ctrl});
      repeat (6) @(posedge clk);
      p0 = pos;
      repeat (4) @(posedge clk);
      if (i == 0) s = p0[31] ^ pos[31] ^ (pos != p0 && pos[31]);
      if (i == 0) s = ($signed(pos - p0) < 0);
      e = (i == 1) ? 32'd20 : 32'd12;
      if (s ^ (i == 2)) e = -e;
      check("jog step", e, pos - p0);
      ctrl[`ASJSC_C_JOGEN] = 1'b0;
      wr(`ASJSC_A_CTRL, {26'h0, ctrl});
      repeat (4) @(posedge clk);
      p0 = pos;
      repeat (3) @(posedge clk);
      check("jog stop", p0, pos);
    end
  endtask
  task automatic t_ovl(input string nm, input logic [31:0] d, b,
                       input logic keep);
    logic [31:0] p0, s0;
    base_in <= b;
    wr(`ASJSC_A_ODIST, d);
    @(posedge clk);
    p0 = pos;
    s0 = base_sum;
    pulse(`ASJSC_C_OVL);
    if (!keep) base_in <= 32'h0;
    wait_stat("overlay done", 8);
    @(posedge clk);
    check(nm, d + (base_sum - s0), pos - p0);
    if (!d[31]) rd_chk("travelled", `ASJSC_A_TRAV, d);
    base_in <= 32'h0;
  endtask
  task automatic t_refuse();
    logic [31:0] p0;
    for (int m = 1; m < 3; m++) begin
      mode <= 2'(m);
      @(posedge clk);
      p0 = pos;
      pulse(`ASJSC_C_OVL);
      wait_stat("overlay error", 12);
      check("no move", p0, pos);
    end
    mode <= 2'h0;
    pulse(`ASJSC_C_HALT);
    wait_stat("halt error", 20);
    rd_chk("faults", `ASJSC_A_FAULT, 32'h10831082);
  endtask
  task automatic t_halt();
    logic [31:0] p0, s0, q;
    base_in <= 32'h1;
    wr(`ASJSC_A_ODIST, 32'h3e8);
    wr(`ASJSC_A_OSPD, 32'h2);
    wr(`ASJSC_A_HDEC, 32'h0);
    pulse(`ASJSC_C_OVL);
    pulse(`ASJSC_C_HALT);
    wait_stat("halt done", 16);
    stat("overlay ended", 11, 1'b1);
    @(posedge clk);
    p0 = pos;
    s0 = base_sum;
    repeat (5) @(posedge clk);
    check("base only", base_sum - s0, pos - p0);
    bus(1'b0, `ASJSC_A_TRAV, 32'h0, q);
    check("cut short", 32'h1, {31'h0, q < 32'h3e8});
    base_in <= 32'h0;
  endtask
  // Cam cycle ends every 16 edges, restarting when the cam is enabled
  task automatic t_skip(input logic re, input logic [31:0] byp);
    logic last;
    hold_ends = 0;
    last = 1'b0;
    wr(`ASJSC_A_SKIPN, 32'h2);
    cam_en <= 1'b1;
    pulse(`ASJSC_C_SKIP);
    for (int n = 0; n < 80 && cam_hold !== 1'b1; n++) begin
      last = cyc_end;
      @(posedge clk);
    end
    check("hold at end", 32'h1, {31'h0, last});
    if (re) begin
      repeat (20) @(posedge clk);
      pulse(`ASJSC_C_SKIP);
    end else begin
      ctrl[`ASJSC_C_SKIP] = 1'b0;
      wr(`ASJSC_A_CTRL, {26'h0, ctrl});
      stat("skip active", 2, 1'b1);
      stat("no early done", 0, 1'b0);
    end
    for (int n = 0; n < 200 && cam_hold === 1'b1; n++) @(posedge clk);
    if (!re) check("held cycles", 32'h2, 32'(hold_ends));
    stat("skip done", 0, 1'b1);
    rd_chk("bypassed", `ASJSC_A_BYP, byp);
    cam_en <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    errors = 0;
    tests_run = 0;
    hold_ends = 0;
    base_sum = 32'h0;
    rstn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    mode = 2'h0;
    cam_en = 1'b0;
    base_in = 32'h0;
    ctrl = 6'h00;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_jog();
    wr(`ASJSC_A_OSPD, 32'h4);
    wr(`ASJSC_A_OACC, 32'h0);
    t_ovl("axis_idle_state", 32'd20, 32'h0, 1'b1);
    t_ovl("reverse", 32'hffffffec, 32'h0, 1'b1);
    t_ovl("on motion", 32'd40, 32'h1, 1'b1);
    t_ovl("after motion", 32'd40, 32'h2, 1'b0);
    t_refuse();
    t_halt();
    pulse(`ASJSC_C_SKIP);
    wait_stat("skip error", 4);
    rd_chk("skip fault", `ASJSC_A_FSKIP, 32'h1090);
    t_skip(1'b0, 32'h2);
    t_skip(1'b1, 32'h3);
    finish_test();
  end
  // Whole run is a few hundred edges; this bound is far above it
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
